// file: scsi_ctrl_pkg.sv
// Constants, register map and state types shared by the module control design
package scsi_ctrl_pkg;

  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam int unsigned CLK_FREQ_HZ          = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS        = 50;
  localparam int unsigned RESET_SETTLE_MS      = 100;
  localparam int unsigned RESET_SETTLE_CYCLES  = (CLK_FREQ_HZ / 1000) * RESET_SETTLE_MS;
  localparam int unsigned MIN_PERIOD_NS        = 200;
  localparam int unsigned MIN_PERIOD_CYCLES    = (MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REF_CLOCK_NS         = 200;
  localparam int unsigned REF_TIMEOUT_CYCLES   = 2 * ((REF_CLOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned BUS_RESET_HOLD_NS    = 25_000;
  localparam int unsigned BUS_RESET_HOLD_CYCLES = BUS_RESET_HOLD_NS / CLK_PERIOD_NS;
  localparam int unsigned MAX_REQ_ACK_OFFSET   = 15;
  localparam int unsigned SCSI_MAX_DEVICES     = 8;

  // ==========================================================
  // Register port
  // ==========================================================
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;

  localparam logic [3:0] REG_CONTROL    = 4'h0;
  localparam logic [3:0] REG_SYNC       = 4'h1;
  localparam logic [3:0] REG_STATUS     = 4'h2;
  localparam logic [3:0] REG_DOWNSTREAM = 4'h3;
  localparam logic [3:0] REG_COMMAND    = 4'h4;
  localparam logic [3:0] REG_TX_DATA    = 4'h5;
  localparam logic [3:0] REG_RX_DATA    = 4'h6;
  localparam logic [3:0] REG_LINK       = 4'h7;

  // Control fields
  localparam int unsigned CTL_ROLE_TARGET  = 0;
  localparam int unsigned CTL_PARITY_CHECK = 1;
  localparam int unsigned CTL_HARD_RESET   = 2;
  localparam int unsigned CTL_OWN_ID_LSB   = 4;
  localparam int unsigned CTL_TARGET_ID_LSB = 8;
  localparam logic [15:0] CONTROL_RESET    = 16'h0070;

  // Sync fields: offset in REQ/ACK pairs, period in clock cycles
  localparam int unsigned SYNC_OFFSET_LSB = 0;
  localparam int unsigned SYNC_PERIOD_LSB = 8;
  localparam logic [15:0] SYNC_RESET      = 16'h0400;

  // Status bits; parity error, bus reset and id clash are write-one-to-clear
  localparam int unsigned ST_PARITY_ERR   = 0;
  localparam int unsigned ST_DS_FAULT     = 1;
  localparam int unsigned ST_CONNECTED    = 2;
  localparam int unsigned ST_BUS_RESET    = 3;
  localparam int unsigned ST_ID_CLASH     = 4;
  localparam int unsigned ST_TX_BUSY      = 5;
  localparam int unsigned ST_REF_CLOCK_OK = 6;
  localparam int unsigned ST_FAULT        = 7;

  // Downstream control bits
  localparam int unsigned DS_RESET_BIT     = 0;
  localparam int unsigned DS_HALT_BIT      = 1;
  localparam logic [15:0] DOWNSTREAM_RESET = 16'h0000;

  // Command bits, write only
  localparam int unsigned CMD_BUS_RESET = 0;
  localparam int unsigned CMD_SELECT    = 1;
  localparam int unsigned CMD_RELEASE   = 2;

  // Link register fields
  localparam int unsigned LINK_FAST_LSB  = 0;
  localparam int unsigned LINK_BOOT_LSB  = 4;
  localparam int unsigned LINK_STATE_LSB = 8;

  typedef enum logic [2:0] {
    SEQ_HELD,
    SEQ_SETTLE,
    SEQ_READY,
    SEQ_RUNNING,
    SEQ_INSPECT
  } seq_state_type;

  typedef enum logic [1:0] {
    SCSI_FREE,
    SCSI_SELECTING,
    SCSI_INITIATOR,
    SCSI_TARGET
  } scsi_state_type;

endpackage : scsi_ctrl_pkg

// file: pin_sync.sv
// Two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta     <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule : pin_sync

`default_nettype wire

// file: req_ack_pacer.sv
// Paces synchronous REQ pulses against period and outstanding offset limits
`timescale 1ns/10ps
`default_nettype none

module req_ack_pacer (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       enable,
  input  wire logic       send,
  input  wire logic [7:0] period,
  input  wire logic [3:0] max_offset,
  input  wire logic       ack_pulse,
  output logic            req,
  output logic            issued,
  output logic [4:0]      outstanding
);

  logic [7:0] period_count;
  logic [4:0] offset_limit;
  logic       below_limit;
  logic       ack_taken;

  // Offset zero means asynchronous: one REQ waits for its ACK
  assign offset_limit = (max_offset == 4'h0) ? 5'h01 : {1'b0, max_offset};
  assign below_limit  = outstanding < offset_limit;
  assign issued       = enable && send && (period_count == 8'h00) && below_limit;
  assign ack_taken    = ack_pulse && (outstanding != 5'h00);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      period_count <= 8'h00;
      req          <= 1'b0;
      outstanding  <= 5'h00;
    end
    else if (!enable)
    begin
      period_count <= 8'h00;
      req          <= 1'b0;
      outstanding  <= 5'h00;
    end
    else
    begin
      // A new REQ waits out a full period from the last one
      if (issued)
        period_count <= period - 8'h01;
      else if (period_count != 8'h00)
        period_count <= period_count - 8'h01;
      // REQ stays high for the first half of the period
      if (issued)
        req <= 1'b1;
      else if (period_count <= {1'b0, period[7:1]})
        req <= 1'b0;
      outstanding <= outstanding + {4'h0, issued} - {4'h0, ack_taken};
    end
  end

endmodule : req_ack_pacer

`default_nettype wire

// file: module_control.sv
// Module reset sequencing, link rate control, fault output and SCSI control
//
// Notes on behaviour
// - Link 0 from first select, others second
// - Module reset clears processor and other circuitry
// - After wait, boot packet accepted on any link
// - Halt with reset stops processor, keeps state
// - Halted processor answers on any link
// - Fault pin open-drain, low while processor errors
// - Names ending _n are active low
// - 5 MHz reference feeds derived internal clocks; here it is only watched for presence, link bit ticks come from clk
// - Two devices talk, at most eight share bus
// - Initiator selects, target then runs transfers
// - Initiator or target role, seven other devices
// - Parity always generated, checking is optional
// - Soft or hard bus reset selectable
// - Offset at most 15, period at least 200 ns
// - Sustain up to 1.5 Mbytes/s
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none

module module_control #(
  parameter int unsigned SETTLE_CYCLES = scsi_ctrl_pkg::RESET_SETTLE_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [15:0] reg_rdata,
  input  wire logic        module_reset_in,
  input  wire logic        analyse_in,
  input  wire logic        reference_clock_in,
  input  wire logic        rate_select_first,
  input  wire logic        rate_select_rest,
  input  wire logic [3:0]  serial_rx_0_3,
  output logic      [3:0]  serial_tx_0_3,
  input  wire logic [3:0]  processor_tx,
  output logic      [3:0]  processor_rx,
  output logic      [3:0]  link_bit_tick,
  input  wire logic        processor_error,
  output logic             processor_reset_out,
  output logic             processor_halt_out,
  output logic             fault_indicator_n_o,
  output logic             fault_indicator_n_oe,
  output logic             downstream_reset_out,
  output logic             downstream_halt_out,
  input  wire logic        downstream_fault_in_n,
  input  wire logic [7:0]  scsi_data_in,
  input  wire logic        scsi_parity_in,
  input  wire logic        scsi_sel_in,
  input  wire logic        scsi_bsy_in,
  input  wire logic        scsi_req_in,
  input  wire logic        scsi_ack_in,
  input  wire logic        scsi_rst_in,
  output logic      [7:0]  scsi_data_out,
  output logic             scsi_parity_out,
  output logic             scsi_data_oe,
  output logic             scsi_line_o,
  output logic             scsi_sel_oe,
  output logic             scsi_bsy_oe,
  output logic             scsi_req_oe,
  output logic             scsi_ack_oe,
  output logic             scsi_rst_oe
);

  import scsi_ctrl_pkg::*;

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic [9:0]  pins_s;
  logic [13:0] scsi_s;

  pin_sync #(.WIDTH(10)) pin_sync_host (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({downstream_fault_in_n, serial_rx_0_3, reference_clock_in,
                rate_select_rest, rate_select_first, analyse_in, module_reset_in}),
    .sync_out (pins_s)
  );

  pin_sync #(.WIDTH(14)) pin_sync_scsi (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({scsi_rst_in, scsi_ack_in, scsi_req_in, scsi_bsy_in, scsi_sel_in,
                scsi_parity_in, scsi_data_in}),
    .sync_out (scsi_s)
  );

  wire       mod_reset  = pins_s[0];
  wire       analyse_s  = pins_s[1];
  wire       rate_first = pins_s[2];
  wire       rate_rest  = pins_s[3];
  wire       ref_s      = pins_s[4];
  wire [3:0] rx_s       = pins_s[8:5];
  wire       ds_fault   = ~pins_s[9];
  wire [7:0] sd_in      = scsi_s[7:0];
  wire       sp_in      = scsi_s[8];
  wire       sel_s      = scsi_s[9];
  wire       bsy_s      = scsi_s[10];
  wire       req_s      = scsi_s[11];
  wire       ack_s      = scsi_s[12];
  wire       srst_s     = scsi_s[13];

  // ==========================================================
  // Reset and halt sequencing
  // ==========================================================
  seq_state_type state;
  seq_state_type next_state;
  logic [20:0]   settle_count;
  logic          analyse_latched;
  logic [3:0]    link_fast;
  logic [3:0]    rx_prev;
  logic [3:0]    boot_link;
  logic          ref_prev;
  logic [3:0]    ref_timer;
  logic          ref_ok;
  logic          slow_phase;

  wire settle_done = settle_count == 21'(SETTLE_CYCLES - 1);
  wire [3:0] rx_start = rx_s & ~rx_prev;
  wire rx_start_any = |rx_start;
  wire link_accept = (state == SEQ_READY) || (state == SEQ_RUNNING) || (state == SEQ_INSPECT);
  wire clear_all = mod_reset & ~analyse_s;
  wire ref_edge = ref_s & ~ref_prev;

  always_comb
  begin
    next_state = state;
    unique case (state)
      SEQ_HELD:
        if (!mod_reset)
          next_state = SEQ_SETTLE;
      SEQ_SETTLE:
        if (mod_reset)
          next_state = SEQ_HELD;
        else if (settle_done)
          next_state = analyse_latched ? SEQ_INSPECT : SEQ_READY;
      SEQ_READY:
        if (mod_reset)
          next_state = SEQ_HELD;
        else if (rx_start_any)
          next_state = SEQ_RUNNING;
      SEQ_RUNNING, SEQ_INSPECT:
        if (mod_reset)
          next_state = SEQ_HELD;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state           <= SEQ_HELD;
      settle_count    <= 21'h0_0000;
      analyse_latched <= 1'b0;
      link_fast       <= 4'h0;
      boot_link       <= 4'h0;
      rx_prev         <= 4'h0;
    end
    else
    begin
      state        <= next_state;
      settle_count <= (state == SEQ_SETTLE) ? settle_count + 21'h0_0001 : 21'h0_0000;
      rx_prev      <= rx_s;
      if (mod_reset)
      begin
        analyse_latched <= analyse_s;
        link_fast       <= {{3{rate_rest}}, rate_first};
      end
      if (clear_all)
        boot_link <= 4'h0;
      else if (state == SEQ_READY && rx_start_any)
        boot_link <= rx_start;
    end
  end

  // ==========================================================
  // Reference clock watch and link bit timing
  // ==========================================================
  // The processor is held in reset while the reference clock is missing
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_prev   <= 1'b0;
      ref_timer  <= 4'h0;
      ref_ok     <= 1'b0;
      slow_phase <= 1'b0;
    end
    else
    begin
      ref_prev   <= ref_s;
      ref_timer  <= ref_edge ? 4'h0 : (ref_ok ? ref_timer + 4'h1 : ref_timer);
      ref_ok     <= ref_edge | (ref_ok & (ref_timer < 4'(REF_TIMEOUT_CYCLES)));
      slow_phase <= ~slow_phase;
    end
  end

  // Fast links take a bit every cycle, slow ones every second cycle
  wire [3:0] next_tick = link_fast | {4{slow_phase}};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link_bit_tick <= 4'h0;
      serial_tx_0_3 <= 4'h0;
      processor_rx  <= 4'h0;
    end
    else
    begin
      link_bit_tick <= next_tick;
      for (int i = 0; i < 4; i++)
        if (next_tick[i])
        begin
          serial_tx_0_3[i] <= link_accept & processor_tx[i];
          processor_rx[i]  <= link_accept & rx_s[i];
        end
    end
  end

  // ==========================================================
  // Processor, fault and downstream outputs
  // ==========================================================
  logic [15:0] ds_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      processor_reset_out  <= 1'b1;
      processor_halt_out   <= 1'b0;
      fault_indicator_n_o  <= 1'b0;
      fault_indicator_n_oe <= 1'b0;
      downstream_reset_out <= 1'b1;
      downstream_halt_out  <= 1'b0;
    end
    else
    begin
      processor_reset_out  <= clear_all | ~ref_ok;
      processor_halt_out   <= (mod_reset & analyse_s) | (state == SEQ_INSPECT);
      fault_indicator_n_o  <= 1'b0;
      fault_indicator_n_oe <= processor_error;
      downstream_reset_out <= ds_reg[DS_RESET_BIT] | clear_all;
      downstream_halt_out  <= ds_reg[DS_HALT_BIT] | (mod_reset & analyse_s);
    end
  end

  // ==========================================================
  // Register port
  // ==========================================================
  logic [15:0] control_reg;
  logic [15:0] sync_reg;
  logic [7:0]  tx_data;
  logic        tx_pending;
  logic [7:0]  rx_data;
  logic        parity_err;
  logic        id_clash;
  logic        bus_reset_seen;
  logic [8:0]  bus_reset_count;
  scsi_state_type scsi_state;

  wire wr_control = reg_write && reg_addr == REG_CONTROL;
  wire wr_sync    = reg_write && reg_addr == REG_SYNC;
  wire wr_status  = reg_write && reg_addr == REG_STATUS;
  wire wr_ds      = reg_write && reg_addr == REG_DOWNSTREAM;
  wire wr_command = reg_write && reg_addr == REG_COMMAND;
  wire wr_tx      = reg_write && reg_addr == REG_TX_DATA;
  wire cmd_reset  = wr_command && reg_wdata[CMD_BUS_RESET];
  wire cmd_select = wr_command && reg_wdata[CMD_SELECT];
  wire cmd_release = wr_command && reg_wdata[CMD_RELEASE];

  wire       role_target = control_reg[CTL_ROLE_TARGET];
  wire       parity_chk  = control_reg[CTL_PARITY_CHECK];
  wire       hard_reset  = control_reg[CTL_HARD_RESET];
  wire [2:0] own_id      = control_reg[CTL_OWN_ID_LSB +: 3];
  wire [2:0] target_id   = control_reg[CTL_TARGET_ID_LSB +: 3];
  wire [7:0] own_bit     = 8'h01 << own_id;
  wire [7:0] target_bit  = 8'h01 << target_id;

  // Period below the legal minimum is raised to it on write
  wire [7:0] wr_period = reg_wdata[SYNC_PERIOD_LSB +: 8];
  wire [7:0] legal_period = (wr_period < 8'(MIN_PERIOD_CYCLES)) ?
                            8'(MIN_PERIOD_CYCLES) : wr_period;

  wire [15:0] status_word = {8'h00, processor_error, ref_ok, tx_pending, id_clash,
                             bus_reset_seen, scsi_state != SCSI_FREE, ds_fault, parity_err};
  wire [15:0] link_word = {5'h00, 3'(state), boot_link, link_fast};
  wire [15:0] rd_value =
    (reg_addr == REG_CONTROL)    ? control_reg :
    (reg_addr == REG_SYNC)       ? sync_reg :
    (reg_addr == REG_STATUS)     ? status_word :
    (reg_addr == REG_DOWNSTREAM) ? ds_reg :
    (reg_addr == REG_TX_DATA)    ? {8'h00, tx_data} :
    (reg_addr == REG_RX_DATA)    ? {8'h00, rx_data} :
    (reg_addr == REG_LINK)       ? link_word : 16'h0000;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata   <= 16'h0000;
      control_reg <= CONTROL_RESET;
      sync_reg    <= SYNC_RESET;
      ds_reg      <= DOWNSTREAM_RESET;
      tx_data     <= 8'h00;
    end
    else if (clear_all)
    begin
      reg_rdata   <= 16'h0000;
      control_reg <= CONTROL_RESET;
      sync_reg    <= SYNC_RESET;
      ds_reg      <= DOWNSTREAM_RESET;
      tx_data     <= 8'h00;
    end
    else
    begin
      reg_rdata <= reg_read ? rd_value : 16'h0000;
      if (wr_control)
        control_reg <= reg_wdata & 16'h0777;
      if (wr_sync)
        sync_reg <= {legal_period, 4'h0, reg_wdata[SYNC_OFFSET_LSB +: 4]};
      if (wr_ds)
        ds_reg <= reg_wdata & 16'h0003;
      if (wr_tx)
        tx_data <= reg_wdata[7:0];
    end
  end

  // ==========================================================
  // SCSI connection control
  // ==========================================================
  scsi_state_type next_scsi;
  logic           req_prev;
  logic           ack_prev;
  logic           pace_req;
  logic           pace_issued;

  wire bus_reset_active = bus_reset_count != 9'h000;
  wire bus_reset_event = srst_s | bus_reset_active;
  wire selected_here = sel_s && !bsy_s && (sd_in & own_bit) != 8'h00;
  wire req_rise = req_s & ~req_prev;
  wire ack_rise = ack_s & ~ack_prev;
  wire rx_parity_bad = parity_chk && !(^{sd_in, sp_in});
  wire clash_now = cmd_select && (target_id == own_id);
  wire abort = bus_reset_active || cmd_release || clear_all;

  always_comb
  begin
    next_scsi = scsi_state;
    unique case (scsi_state)
      SCSI_FREE:
        if (!abort && !role_target && cmd_select && !clash_now && !bsy_s)
          next_scsi = SCSI_SELECTING;
        else if (!abort && role_target && selected_here)
          next_scsi = SCSI_TARGET;
      SCSI_SELECTING:
        if (abort)
          next_scsi = SCSI_FREE;
        else if (bsy_s)
          next_scsi = SCSI_INITIATOR;
      SCSI_INITIATOR:
        if (abort || !bsy_s)
          next_scsi = SCSI_FREE;
      SCSI_TARGET:
        if (abort)
          next_scsi = SCSI_FREE;
    endcase
  end

  // Only the target drives REQ, so pacing runs in the target role
  req_ack_pacer pacer (
    .clk         (clk),
    .rst_n       (rst_n),
    .enable      (scsi_state == SCSI_TARGET),
    .send        (tx_pending),
    .period      (sync_reg[SYNC_PERIOD_LSB +: 8]),
    .max_offset  (sync_reg[SYNC_OFFSET_LSB +: 4]),
    .ack_pulse   (ack_rise),
    .req         (pace_req),
    .issued      (pace_issued),
    .outstanding ()
  );

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scsi_state      <= SCSI_FREE;
      req_prev        <= 1'b0;
      ack_prev        <= 1'b0;
      rx_data         <= 8'h00;
      tx_pending      <= 1'b0;
      parity_err      <= 1'b0;
      id_clash        <= 1'b0;
      bus_reset_seen  <= 1'b0;
      bus_reset_count <= 9'h000;
    end
    else
    begin
      scsi_state <= next_scsi;
      req_prev   <= req_s;
      ack_prev   <= ack_s;
      if (scsi_state == SCSI_INITIATOR && req_rise)
        rx_data <= sd_in;
      // A new byte written beside a consumed one wins
      if (wr_tx)
        tx_pending <= 1'b1;
      else if (pace_issued || clear_all || (bus_reset_active && hard_reset))
        tx_pending <= 1'b0;
      // Set wins over a write-one clear
      parity_err <= (scsi_state == SCSI_INITIATOR && req_rise && rx_parity_bad) |
                    (parity_err & ~(wr_status & reg_wdata[ST_PARITY_ERR]));
      id_clash <= clash_now | (id_clash & ~(wr_status & reg_wdata[ST_ID_CLASH]));
      bus_reset_seen <= bus_reset_event |
                        (bus_reset_seen & ~(wr_status & reg_wdata[ST_BUS_RESET]));
      if (cmd_reset)
        bus_reset_count <= 9'(BUS_RESET_HOLD_CYCLES);
      else if (bus_reset_active)
        bus_reset_count <= bus_reset_count - 9'h001;
    end
  end

  // ==========================================================
  // SCSI pin drivers
  // ==========================================================
  wire       drive_data = (scsi_state == SCSI_SELECTING) || (scsi_state == SCSI_TARGET);
  wire [7:0] next_data  = (scsi_state == SCSI_SELECTING) ? (own_bit | target_bit) : tx_data;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scsi_data_out   <= 8'h00;
      scsi_parity_out <= 1'b0;
      scsi_data_oe    <= 1'b0;
      scsi_line_o     <= 1'b0;
      scsi_sel_oe     <= 1'b0;
      scsi_bsy_oe     <= 1'b0;
      scsi_req_oe     <= 1'b0;
      scsi_ack_oe     <= 1'b0;
      scsi_rst_oe     <= 1'b0;
    end
    else
    begin
      scsi_data_out   <= next_data;
      scsi_parity_out <= ~^next_data;
      scsi_data_oe    <= drive_data;
      scsi_line_o     <= 1'b0;
      scsi_sel_oe     <= scsi_state == SCSI_SELECTING;
      scsi_bsy_oe     <= scsi_state == SCSI_TARGET;
      scsi_req_oe     <= pace_req;
      scsi_ack_oe     <= (scsi_state == SCSI_INITIATOR) && req_s;
      scsi_rst_oe     <= bus_reset_active;
    end
  end

endmodule : module_control

`default_nettype wire

// file: module_control_monitor.sv
// Port checker for the module control block
`timescale 1ns/10ps
`default_nettype none
module module_control_monitor (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       module_reset_in,
  input wire logic       analyse_in,
  input wire logic       processor_error,
  input wire logic       fault_indicator_n_o,
  input wire logic       fault_indicator_n_oe,
  input wire logic       downstream_reset_out,
  input wire logic       downstream_halt_out,
  input wire logic       processor_reset_out,
  input wire logic       processor_halt_out,
  input wire logic [7:0] scsi_data_out,
  input wire logic       scsi_parity_out,
  input wire logic       scsi_data_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Five cycles cover the pin synchroniser plus the output register
  wire hold = module_reset_in & !analyse_in;
  wire look = module_reset_in & analyse_in;
  chk_fault_pull: assert property (processor_error |=> fault_indicator_n_oe)
    else $error("fault pin not pulled");
  chk_fault_free: assert property (!processor_error |=> !fault_indicator_n_oe)
    else $error("fault pin not released");
  chk_fault_level: assert property (fault_indicator_n_oe |-> !fault_indicator_n_o)
    else $error("fault pin driven high");
  chk_proc_reset: assert property (hold [*5] |-> processor_reset_out)
    else $error("processor not held in reset");
  chk_down_reset: assert property (hold [*5] |-> downstream_reset_out)
    else $error("downstream reset missing");
  chk_proc_halt: assert property (look [*5] |-> processor_halt_out)
    else $error("processor not halted");
  chk_down_halt: assert property (look [*5] |-> downstream_halt_out)
    else $error("downstream halt missing");
  chk_parity_odd: assert property (scsi_data_oe |-> ^{scsi_data_out, scsi_parity_out})
    else $error("parity not odd");
  cover property (processor_error ##1 fault_indicator_n_oe);
  cover property (look [*5] ##1 processor_halt_out);
  cover property (scsi_data_oe);
endmodule : module_control_monitor
bind module_control module_control_monitor i_mon (.*);
`default_nettype wire

// file: host_model.sv
// Host side: reference clock, module reset, analyse and link lines
`timescale 1ns/10ps
`default_nettype none
module host_model #(parameter int SETTLE = 20) (
  output logic       reference_clock_in,
  output logic       module_reset_in,
  output logic       analyse_in,
  output logic [3:0] serial_rx_0_3
);
  initial reference_clock_in = 0;
  always #100 reference_clock_in = ~reference_clock_in;
  initial {module_reset_in, analyse_in, serial_rx_0_3} = 0;
  // Idle links sit low through their pull-downs
  task automatic pulse(input logic an);
    analyse_in <= an;
    module_reset_in <= 1;
    #(SETTLE * 50 + 500) module_reset_in <= 0;
    #(SETTLE * 50 + 500);
  endtask : pulse
  task automatic boot(input int k);
    serial_rx_0_3[k] <= 1;
    #100 serial_rx_0_3[k] <= 0;
  endtask : boot
endmodule : host_model
`default_nettype wire

// file: module_control_tb.sv
// Self-checking testbench for the module control block
`timescale 1ns/10ps
`default_nettype none
module module_control_tb;
  logic clk = 0, rst_n = 0, reg_write = 0, reg_read = 0, processor_error = 0;
  logic downstream_fault_in_n = 1, rate_select_first = 0, rate_select_rest = 0;
  logic scsi_parity_in = 0, scsi_sel_in = 0, scsi_bsy_in = 0, scsi_req_in = 0;
  logic scsi_ack_in = 0, scsi_rst_in = 0, reference_clock_in, module_reset_in, analyse_in;
  logic [3:0] reg_addr = 0, serial_rx_0_3, serial_tx_0_3, processor_tx = 0;
  logic [3:0] processor_rx, link_bit_tick;
  logic [15:0] reg_wdata = 0, reg_rdata;
  logic [7:0] scsi_data_in = 0, scsi_data_out;
  logic processor_reset_out, processor_halt_out, fault_indicator_n_o, fault_indicator_n_oe;
  logic downstream_reset_out, downstream_halt_out, scsi_parity_out, scsi_data_oe;
  logic scsi_line_o, scsi_sel_oe, scsi_bsy_oe, scsi_req_oe, scsi_ack_oe, scsi_rst_oe;
  int error_cnt = 0, n_compared = 0;
  // Fault line modelled as pulled high, low while this block drives the pin
  wire fault_line = ~fault_indicator_n_oe;
  module_control #(.SETTLE_CYCLES(20)) i_dut (.*);
  host_model i_host (.*);
  always #25 clk = ~clk;
  task automatic check(input string nm, input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1;
    @(posedge clk);
    reg_write <= 0;
  endtask : wr
  task automatic rc(input string nm, input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1;
    @(posedge clk);
    reg_read <= 0;
    #1 check(nm, reg_rdata, exp);
  endtask : rc
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic t_links;
    for (int c = 0; c < 4; c++)
    begin
      @(posedge clk);
      {rate_select_rest, rate_select_first} <= c[1:0];
      i_host.pulse(0);
      {rate_select_rest, rate_select_first} <= ~c[1:0];
      rc("ready", 7, {5'h0, 3'd2, 4'h0, {3{c[1]}}, c[0]});
      i_host.boot(c);
      settle(6);
      rc("boot", 7, {5'h0, 3'd3, 4'h1 << c, {3{c[1]}}, c[0]});
    end
  endtask : t_links
  task automatic t_halt;
    fork
      i_host.pulse(1);
      settle(10);
    join_any
    check("halt", {downstream_halt_out, processor_halt_out}, 2'b11);
    wait fork;
    check("inspect", processor_halt_out, 1'b1);
  endtask : t_halt
  task automatic t_fault;
    @(posedge clk) processor_error <= 1;
    settle(2);
    check("fault", {fault_indicator_n_oe, fault_indicator_n_o, fault_line}, 3'b100);
    @(posedge clk) processor_error <= 0;
  endtask : t_fault
  task automatic t_down;
    @(posedge clk) downstream_fault_in_n <= 0;
    wr(3, 16'h0003);
    settle(3);
    check("ds", {downstream_halt_out, downstream_reset_out}, 2'b11);
    rc("status", 2, 16'h0042);
    wr(3, 16'h0000);
  endtask : t_down
  task automatic t_scsi;
    wr(1, 16'h010F);
    rc("sync", 1, 16'h040F);
    wr(0, 16'h0370);
    wr(4, 16'h0002);
    settle(2);
    check("sel", {scsi_sel_oe, scsi_data_oe, scsi_parity_out, scsi_data_out}, 16'h0788);
    wr(4, 16'h0001);
    settle(2);
    check("busrst", scsi_rst_oe, 1'b1);
    rc("rstseen", 2, 16'h004A);
  endtask : t_scsi
  task automatic summarize;
    $display("checks %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1;
    t_links;
    t_halt;
    t_fault;
    t_down;
    t_scsi;
    summarize;
  end
  initial
  begin
    #200000;
    error_cnt++;
    summarize;
  end
endmodule : module_control_tb
`default_nettype wire
